// *** hdl/twh_handshake.sv ***
// source and acceptor ends of the three-wire byte handshake
`timescale 1ns/100ps
`default_nettype none

module twh_handshake
  import twh_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // bus lines, sensed levels
  input  wire logic [TWH_DATA_W-1:0] dio_in,
  input  wire logic                  dav_in,
  input  wire logic                  nrfd_in,
  input  wire logic                  ndac_in,
  input  wire logic                  atn_in,
  // bus lines, drive (handshake lines low when enabled, data lines carry dio_out)
  output logic      [TWH_DATA_W-1:0] dio_out,
  output logic      [TWH_DATA_W-1:0] dio_oe_out,
  output logic                       dav_out,
  output logic                       dav_oe_out,
  output logic                       nrfd_out,
  output logic                       nrfd_oe_out,
  output logic                       ndac_out,
  output logic                       ndac_oe_out,
  // user roles
  input  wire logic                  talk_en_in,
  input  wire logic                  listen_en_in,
  input  wire logic                  cmd_src_in,
  // source user side
  input  wire logic                  tx_valid_in,
  input  wire logic [TWH_DATA_W-1:0] tx_data_in,
  output logic                       tx_ready_out,
  output logic                       tx_done_out,
  input  wire logic                  err_clr_in,
  output logic                       err_out,
  // acceptor user side
  input  wire logic                  rx_ready_in,
  output logic                       rx_valid_out,
  output logic      [TWH_DATA_W-1:0] rx_data_out,
  output logic                       rx_cmd_out,
  output logic      [TWH_CHAR_W-1:0] rx_char_out
);

  // synchroniser stages, first stage read only by second
  logic [3:0]            sync1_reg;      // atn, ndac, nrfd, dav
  logic [3:0]            sync2_reg;      // settled copies
  logic [TWH_DATA_W-1:0] dio1_reg;       // data line first stage
  logic [TWH_DATA_W-1:0] dio2_reg;       // data line second stage
  logic                  dav_s;          // synced data valid
  logic                  nrfd_s;         // synced not ready
  logic                  ndac_s;         // synced not accepted
  logic                  atn_s;          // synced attention
  logic                  src_active;     // allowed to source now
  logic                  acc_active;     // allowed to accept now
  twh_src_type           src_reg;        // source state
  twh_acc_type           acc_reg;        // acceptor state
  logic [TWH_CNT_W-1:0]  settle_reg;     // settle countdown
  logic [TWH_CNT_W-1:0]  rate_reg;       // byte period countdown
  logic                  dav_low_reg;    // source pulls valid low
  logic                  nrfd_low_reg;   // acceptor pulls ready low
  logic                  ndac_low_reg;   // acceptor pulls accepted low
  logic [TWH_CNT_W-1:0]  gap_cnt_reg;    // cycles since last byte taken

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      dio1_reg  <= TWH_DATA_RST;
      dio2_reg  <= TWH_DATA_RST;
    end else begin
      sync1_reg <= {atn_in, ndac_in, nrfd_in, dav_in};
      sync2_reg <= sync1_reg;
      dio1_reg  <= dio_in;
      dio2_reg  <= dio1_reg;
    end
  end

  assign dav_s  = sync2_reg[0];
  assign nrfd_s = sync2_reg[1];
  assign ndac_s = sync2_reg[2];
  assign atn_s  = sync2_reg[3];

  // talk only in data mode; command source when atn low; accept when listening or atn low
  assign src_active = cmd_src_in ? ~atn_s : (talk_en_in & atn_s);
  assign acc_active = listen_en_in | ~atn_s;

  // source sequence
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_reg      <= TWH_SRC_IDLE;
      settle_reg   <= '0;
      rate_reg     <= '0;
      dav_low_reg  <= 1'b0;
      dio_out      <= TWH_DATA_RST;
      dio_oe_out   <= '0;
      tx_ready_out <= 1'b0;
      tx_done_out  <= 1'b0;
      err_out      <= 1'b0;
    end else begin
      tx_done_out  <= 1'b0;
      tx_ready_out <= 1'b0;
      if (rate_reg != '0) begin
        rate_reg <= rate_reg - 1'b1;
      end
      unique case (src_reg)
        TWH_SRC_IDLE: begin
          dio_oe_out <= '0;
          if (src_active && tx_valid_in && rate_reg == '0) begin
            // both-high error checked before placing byte
            if (nrfd_s && ndac_s) begin
              err_out <= 1'b1;
              src_reg <= TWH_SRC_ERR;
            end else begin
              // byte driven on all eight lines
              dio_out      <= tx_data_in;
              dio_oe_out   <= '1;
              tx_ready_out <= 1'b1;
              settle_reg   <= TWH_CNT_W'(TWH_SETTLE_CYC);
              rate_reg     <= TWH_CNT_W'(TWH_MIN_BYTE_CYC);
              src_reg      <= TWH_SRC_SETTLE;
            end
          end
        end
        TWH_SRC_SETTLE: begin
          if (settle_reg <= 1) begin
            src_reg <= TWH_SRC_WREADY;
          end else begin
            settle_reg <= settle_reg - 1'b1;
          end
        end
        TWH_SRC_WREADY: begin
          if (nrfd_s) begin
            dav_low_reg <= 1'b1;
            src_reg     <= TWH_SRC_WACC;
          end
        end
        // valid released once wired accepted high
        TWH_SRC_WACC: begin
          if (ndac_s) begin
            dav_low_reg <= 1'b0;
            tx_done_out <= 1'b1;
            src_reg     <= TWH_SRC_GAP;
          end
        end
        // data removed only after valid high
        TWH_SRC_GAP: begin
          // keep data until the valid pin itself is released
          if (!dav_oe_out) begin
            dio_oe_out <= '0;
            src_reg    <= TWH_SRC_IDLE;
          end
        end
        TWH_SRC_ERR: begin
          if (err_clr_in) begin
            err_out <= 1'b0;
            src_reg <= TWH_SRC_IDLE;
          end
        end
        default: begin
          src_reg <= TWH_SRC_IDLE;
        end
      endcase
    end
  end

  // acceptor sequence
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_reg      <= TWH_ACC_BUSY;
      nrfd_low_reg <= 1'b1;
      ndac_low_reg <= 1'b1;
      rx_valid_out <= 1'b0;
      rx_data_out  <= TWH_DATA_RST;
      rx_cmd_out   <= 1'b0;
      rx_char_out  <= '0;
    end else begin
      rx_valid_out <= 1'b0;
      unique case (acc_reg)
        // release ready when user side ready and valid high
        TWH_ACC_BUSY: begin
          ndac_low_reg <= 1'b1;
          if (!acc_active) begin
            nrfd_low_reg <= 1'b0;
            ndac_low_reg <= 1'b0;
          end else if (rx_ready_in && dav_s) begin
            nrfd_low_reg <= 1'b0;
            acc_reg      <= TWH_ACC_READY;
          end
        end
        // withdraw ready first on valid low
        TWH_ACC_READY: begin
          if (!acc_active) begin
            acc_reg <= TWH_ACC_BUSY;
          end else if (!dav_s) begin
            nrfd_low_reg <= 1'b1;
            acc_reg      <= TWH_ACC_TAKE;
          end
        end
        TWH_ACC_TAKE: begin
          rx_data_out  <= dio2_reg;
          rx_char_out  <= dio2_reg[TWH_CHAR_W-1:0];
          rx_cmd_out   <= ~atn_s;
          rx_valid_out <= 1'b1;
          ndac_low_reg <= 1'b0;
          acc_reg      <= TWH_ACC_DONE;
        end
        // pull accepted low again on valid high
        TWH_ACC_DONE: begin
          if (dav_s) begin
            ndac_low_reg <= 1'b1;
            acc_reg      <= TWH_ACC_BUSY;
          end
        end
      endcase
    end
  end

  // open drain drive of valid, ready and accepted, driven only low or released
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dav_out     <= 1'b0;
      dav_oe_out  <= 1'b0;
      nrfd_out    <= 1'b0;
      nrfd_oe_out <= 1'b0;
      ndac_out    <= 1'b0;
      ndac_oe_out <= 1'b0;
    end else begin
      dav_out     <= 1'b0;
      nrfd_out    <= 1'b0;
      ndac_out    <= 1'b0;
      dav_oe_out  <= dav_low_reg;
      nrfd_oe_out <= nrfd_low_reg & listen_en_in;
      ndac_oe_out <= ndac_low_reg & listen_en_in;
    end
  end

  // cycles since a byte was taken, saturating
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_cnt_reg <= '1;
    end else if (tx_ready_out) begin
      gap_cnt_reg <= '0;
    end else if (gap_cnt_reg != '1) begin
      gap_cnt_reg <= gap_cnt_reg + 1'b1;
    end
  end

  // assertions
  property p_settle;
    @(posedge clk_in) disable iff (rst_in)
    $rose(tx_ready_out) |-> !dav_low_reg [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("valid asserted before settling");

  property p_ready_first;
    @(posedge clk_in) disable iff (rst_in)
    $rose(dav_low_reg) |-> $past(nrfd_s);
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("valid without ready");

  property p_release;
    @(posedge clk_in) disable iff (rst_in)
    $fell(dav_low_reg) |-> $past(ndac_s);
  endproperty
  a_release: assert property (p_release) else $error("valid released early");

  property p_hold;
    @(posedge clk_in) disable iff (rst_in)
    dav_low_reg |-> $stable(dio_out) && dio_oe_out == '1;
  endproperty
  a_hold: assert property (p_hold) else $error("data changed under valid");

  property p_settle_full;
    @(posedge clk_in) disable iff (rst_in)
    $rose(dav_low_reg) |-> gap_cnt_reg >= TWH_CNT_W'(TWH_SETTLE_CYC);
  endproperty
  a_settle_full: assert property (p_settle_full) else $error("settle shorter than set");

  property p_data_after;
    @(posedge clk_in) disable iff (rst_in)
    $fell(dav_oe_out) |-> dio_oe_out == '1;
  endproperty
  a_data_after: assert property (p_data_after) else $error("data dropped with valid");

  property p_take;
    @(posedge clk_in) disable iff (rst_in)
    rx_valid_out |-> $past(nrfd_low_reg) && !ndac_low_reg;
  endproperty
  a_take: assert property (p_take) else $error("capture before ready withdrawn");

  property p_ndac;
    @(posedge clk_in) disable iff (rst_in)
    (acc_reg == TWH_ACC_DONE && dav_s) |=> ndac_low_reg;
  endproperty
  a_ndac: assert property (p_ndac) else $error("accepted not pulled low");

  property p_err;
    @(posedge clk_in) disable iff (rst_in)
    err_out |-> !dav_low_reg && src_reg == TWH_SRC_ERR;
  endproperty
  a_err: assert property (p_err) else $error("source not halted on error");

  property p_od;
    @(posedge clk_in) disable iff (rst_in)
    !dav_out && !nrfd_out && !ndac_out;
  endproperty
  a_od: assert property (p_od) else $error("line driven high");

  property p_rate;
    @(posedge clk_in) disable iff (rst_in)
    tx_ready_out |-> gap_cnt_reg >= TWH_CNT_W'(TWH_MIN_BYTE_CYC);
  endproperty
  a_rate: assert property (p_rate) else $error("bytes too close");

  c_byte_out: cover property (@(posedge clk_in) disable iff (rst_in) tx_done_out);
  c_byte_in:  cover property (@(posedge clk_in) disable iff (rst_in) rx_valid_out);
  c_error:    cover property (@(posedge clk_in) disable iff (rst_in) $rose(err_out));
  c_cmd_in:   cover property (@(posedge clk_in) disable iff (rst_in) rx_valid_out && rx_cmd_out);

endmodule

`default_nettype wire

// *** hdl/twh_pkg.sv ***
// package of constants and state types for the three-wire byte handshake
package twh_pkg;
  // data path
  localparam int          TWH_DATA_W       = 8;
  localparam int          TWH_CHAR_W       = 7;
  // settling delay before data valid is asserted
  localparam int          TWH_SETTLE_NS    = 50;
  localparam int          TWH_CLK_NS       = 5;
  localparam int          TWH_SETTLE_CYC   = (TWH_SETTLE_NS + TWH_CLK_NS - 1) / TWH_CLK_NS;
  // fastest byte period: 1 megabyte per second
  localparam int          TWH_MIN_BYTE_NS  = 1000;
  localparam int          TWH_MIN_BYTE_CYC = (TWH_MIN_BYTE_NS + TWH_CLK_NS - 1) / TWH_CLK_NS;
  localparam int          TWH_CNT_W        = 8;
  // reset values
  localparam logic [7:0]  TWH_DATA_RST     = 8'h00;
  // source states
  typedef enum logic [2:0] {
    TWH_SRC_IDLE   = 3'b000,
    TWH_SRC_SETTLE = 3'b001,
    TWH_SRC_WREADY = 3'b010,
    TWH_SRC_WACC   = 3'b011,
    TWH_SRC_GAP    = 3'b100,
    TWH_SRC_ERR    = 3'b101
  } twh_src_type;
  // acceptor states
  typedef enum logic [1:0] {
    TWH_ACC_READY = 2'b00,
    TWH_ACC_TAKE  = 2'b01,
    TWH_ACC_DONE  = 2'b10,
    TWH_ACC_BUSY  = 2'b11
  } twh_acc_type;
endpackage

// *** sim/twh_partner.sv ***
// far-side bus instrument: acceptor and source
`timescale 1ns/100ps
`default_nettype none
module twh_partner (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // bench control
  input  wire logic       acc_en_in,
  input  wire logic [7:0] dly_in,
  input  wire logic       go_in,
  input  wire logic [7:0] data_in,
  // sensed line levels
  input  wire logic       dav_in,
  input  wire logic       nrfd_in,
  input  wire logic       ndac_in,
  input  wire logic [7:0] dio_in,
  // pulls, high = line low; data drive, received byte and source busy
  output logic            dav_pull_out,
  output logic            nrfd_pull_out,
  output logic            ndac_pull_out,
  output logic            dio_oe_out,
  output logic [7:0]      dio_out,
  output logic [7:0]      rx_out,
  output logic            busy_out
);
  logic [7:0] acnt_reg; // readiness delay
  logic [3:0] scnt_reg; // settle count
  logic [2:0] st_reg;   // source step
  assign busy_out = (st_reg != 3'h0);
  // acceptor, paced by dly_in
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nrfd_pull_out <= 1'b0;
      ndac_pull_out <= 1'b0;
      acnt_reg      <= 8'h00;
      rx_out        <= 8'h00;
    end else if (!acc_en_in) begin
      nrfd_pull_out <= 1'b0;
      ndac_pull_out <= 1'b0;
    end else if (!dav_in && !nrfd_pull_out) begin
      nrfd_pull_out <= 1'b1;
    end else if (!dav_in && ndac_pull_out) begin
      rx_out        <= dio_in;
      ndac_pull_out <= 1'b0;
    end else if (dav_in && !ndac_pull_out) begin
      ndac_pull_out <= 1'b1;
      acnt_reg      <= dly_in;
    end else if (dav_in && acnt_reg != 8'h00) begin
      acnt_reg <= acnt_reg - 8'h01;
    end else if (dav_in) begin
      nrfd_pull_out <= 1'b0;
    end
  end
  // source sequence
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg       <= 3'h0;
      scnt_reg     <= 4'h0;
      dav_pull_out <= 1'b0;
      dio_oe_out   <= 1'b0;
      dio_out      <= 8'h00;
    end else if (st_reg == 3'h0 && go_in && !(nrfd_in && ndac_in)) begin
      dio_oe_out <= 1'b1;
      dio_out    <= data_in;
      scnt_reg   <= 4'hA;
      st_reg     <= 3'h1;
    end else if (st_reg == 3'h1) begin
      scnt_reg <= scnt_reg - 4'h1;
      st_reg   <= (scnt_reg == 4'h1) ? 3'h2 : 3'h1;
    end else if (st_reg == 3'h2 && nrfd_in) begin
      dav_pull_out <= 1'b1;
      st_reg       <= 3'h3;
    end else if (st_reg == 3'h3 && ndac_in) begin
      dav_pull_out <= 1'b0;
      st_reg       <= 3'h4;
    end else if (st_reg == 3'h4) begin
      dio_oe_out <= 1'b0;
      st_reg     <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// *** sim/twh_handshake_tb.sv ***
// testbench for the handshake block
`timescale 1ns/100ps
`default_nettype none
module twh_handshake_tb;
  import twh_pkg::*;
  logic       clk_in, rst_in, talk, listen, cmd, atn, txv, rxr, clr, acc, go;
  logic       dav_o, dav_oe, nrfd_o, nrfd_oe, ndac_o, ndac_oe;
  logic       tx_rdy, tx_done, err, rx_v, rx_cmd, p_dav, p_nrfd, p_ndac, p_oe, p_busy;
  logic [7:0] txd, dly, sdat, dout, doe, rx_d, p_dio, p_rx;
  logic [6:0] rx_ch;
  int         cyc = 0;
  int         miscompares = 0;
  int         comparisons = 0;
  // wired lines with pull-ups
  wire logic       dav_l  = ~(dav_oe | p_dav);
  wire logic       nrfd_l = ~(nrfd_oe | p_nrfd);
  wire logic       ndac_l = ~(ndac_oe | p_ndac);
  wire logic [7:0] dio_l  = (doe & dout) | (~doe & (p_oe ? p_dio : 8'hFF));
  twh_handshake u_dut (.clk_in(clk_in), .rst_in(rst_in), .dio_in(dio_l), .dav_in(dav_l),
    .nrfd_in(nrfd_l), .ndac_in(ndac_l), .atn_in(atn), .dio_out(dout), .dio_oe_out(doe),
    .dav_out(dav_o), .dav_oe_out(dav_oe), .nrfd_out(nrfd_o), .nrfd_oe_out(nrfd_oe),
    .ndac_out(ndac_o), .ndac_oe_out(ndac_oe), .talk_en_in(talk), .listen_en_in(listen),
    .cmd_src_in(cmd), .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(tx_rdy),
    .tx_done_out(tx_done), .err_clr_in(clr), .err_out(err), .rx_ready_in(rxr),
    .rx_valid_out(rx_v), .rx_data_out(rx_d), .rx_cmd_out(rx_cmd), .rx_char_out(rx_ch));
  twh_partner u_far (.clk_in(clk_in), .rst_in(rst_in), .acc_en_in(acc), .dly_in(dly),
    .go_in(go), .data_in(sdat), .dav_in(dav_l), .nrfd_in(nrfd_l), .ndac_in(ndac_l),
    .dio_in(dio_l), .dav_pull_out(p_dav), .nrfd_pull_out(p_nrfd), .ndac_pull_out(p_ndac),
    .dio_oe_out(p_oe), .dio_out(p_dio), .rx_out(p_rx), .busy_out(p_busy));
  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // cycle count and hang limit
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input logic c, input string m);
    comparisons++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one byte from the block to the far acceptor
  task automatic src_byte(input logic [7:0] d, output int t0);
    int   n;
    logic done;
    done = 1'b0;
    txd = d;
    txv = 1'b1;
    for (n = 0; n < 900 && tx_rdy !== 1'b1; n++) @(negedge clk_in);
    t0 = cyc;
    txv = 1'b0;
    for (n = 0; n < 900 && dav_oe !== 1'b1; n++) @(negedge clk_in);
    chk(nrfd_l === 1'b1, "valid before ready");
    chk(cyc - t0 >= TWH_SETTLE_CYC, "settle too short");
    for (n = 0; n < 900 && dav_oe === 1'b1; n++) begin
      chk(dio_l === d, "data moved under valid");
      if (tx_done === 1'b1) done = 1'b1;
      @(negedge clk_in);
    end
    chk(done && dav_l === 1'b1 && p_rx === d, "byte lost");
    chk(doe === 8'hFF && dio_l === d, "data dropped with valid");
  endtask
  // one byte from the far source into the block
  task automatic p_byte(input logic [7:0] d, input logic c);
    int n;
    sdat = d;
    go = 1'b1;
    @(negedge clk_in);
    go = 1'b0;
    for (n = 0; n < 900 && rx_v !== 1'b1; n++) @(negedge clk_in);
    chk(rx_v === 1'b1 && nrfd_oe === 1'b1 && ndac_oe === 1'b1, "took while ready");
    chk(rx_d === d && rx_ch === d[6:0] && rx_cmd === c, "wrong byte");
    @(negedge clk_in);
    chk(ndac_oe === 1'b0, "accepted not released");
    for (n = 0; n < 900 && p_busy === 1'b1; n++) @(negedge clk_in);
    repeat (5) @(negedge clk_in);
    chk(dav_l === 1'b1 && ndac_oe === 1'b1, "not idle after byte");
  endtask
  task automatic t_talk();
    int t;
    talk = 1'b1;
    acc = 1'b1;
    dly = 8'h3C;
    repeat (5) @(negedge clk_in);
    src_byte(8'hA5, t);
    repeat (10) @(negedge clk_in);
    chk(ndac_l === 1'b0 && dav_l === 1'b1, "lines not idle");
  endtask
  task automatic t_rate();
    int a, b;
    dly = 8'h00;
    src_byte(8'h5A, a);
    src_byte(8'hC3, b);
    chk(b - a >= TWH_MIN_BYTE_CYC, "bytes too close");
  endtask
  task automatic t_cmd();
    int a;
    talk = 1'b0;
    cmd = 1'b1;
    atn = 1'b0;
    repeat (5) @(negedge clk_in);
    src_byte(8'h3F, a);
    cmd = 1'b0;
    atn = 1'b1;
  endtask
  task automatic t_err();
    int n;
    talk = 1'b1;
    acc = 1'b0;
    repeat (10) @(negedge clk_in);
    txd = 8'h77;
    txv = 1'b1;
    for (n = 0; n < 300 && err !== 1'b1; n++) @(negedge clk_in);
    repeat (10) @(negedge clk_in);
    chk(err === 1'b1 && doe === 8'h00 && dav_oe === 1'b0, "error not raised");
    txv = 1'b0;
    clr = 1'b1;
    @(negedge clk_in);
    clr = 1'b0;
    repeat (3) @(negedge clk_in);
    chk(err === 1'b0, "error stuck");
    talk = 1'b0;
  endtask
  task automatic t_listen();
    listen = 1'b1;
    repeat (10) @(negedge clk_in);
    rxr = 1'b0;
    p_byte(8'hC5, 1'b0);
    chk(nrfd_oe === 1'b1, "ready without user");
    rxr = 1'b1;
    repeat (10) @(negedge clk_in);
    chk(nrfd_oe === 1'b0 && {dav_o, nrfd_o, ndac_o} === 3'h0, "not ready again");
    atn = 1'b0;
    repeat (5) @(negedge clk_in);
    p_byte(8'h21, 1'b1);
    listen = 1'b0;
    atn = 1'b1;
    repeat (10) @(negedge clk_in);
    chk(nrfd_oe === 1'b0 && ndac_oe === 1'b0, "unaddressed drives");
  endtask
  // main sequence
  initial begin
    {rst_in, atn, rxr} = 3'h7;
    {talk, listen, cmd, txv, clr, acc, go} = 7'h00;
    {txd, dly, sdat} = 24'h000000;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (5) @(negedge clk_in);
    t_talk();
    t_rate();
    t_cmd();
    t_err();
    t_listen();
    test_done();
  end
endmodule
`default_nettype wire
